/* File: test/acr_host_model.sv */
// Host model: takes master-mode serial frames and times the serial clock.
// Assumes registered device outputs, sampled on the 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
   input  wire logic   clk_in,
   input  wire logic   rst_n_in,
   input  wire logic   sclk_in,
   input  wire logic   sync_in,
   input  wire logic   sd_in,
   output logic [15:0] word_out,
   output logic [5:0]  nbits_out,
   output logic [9:0]  per_min_out,
   output logic [9:0]  per_max_out,
   output logic        chain_out
);
   logic       sclk_q;
   logic       sync_q;
   logic [9:0] cnt_q;
   wire logic  rise = sclk_in && !sclk_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {sclk_q, sync_q, word_out, nbits_out, cnt_q, per_max_out} <= '0;
         per_min_out <= 10'h3FF;
         chain_out <= 1'b0;
      end else begin
         sclk_q <= sclk_in;
         sync_q <= sync_in;
         chain_out <= ~chain_out;
         cnt_q <= rise ? 10'h001 : cnt_q + 10'h001;
         if (sync_in && !sync_q) begin
            {word_out, nbits_out, per_max_out} <= '0;
            per_min_out <= 10'h3FF;
         end else if (sync_in && rise) begin
            word_out <= {word_out[14:0], sd_in};
            nbits_out <= nbits_out + 6'h01;
            if (nbits_out != 6'h00) begin
               per_min_out <= (cnt_q < per_min_out) ? cnt_q : per_min_out;
               per_max_out <= (cnt_q > per_max_out) ? cnt_q : per_max_out;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: test/acr_top_asserts.sv */
// Checker of busy, bus and frame timing at the block's ports.
// Assumes one clock domain; bound into every acr_top.
`timescale 1ns/1ps
`default_nettype none
module acr_top_asserts #(
   parameter int DATA_W = 16
) (
   input wire logic               clk_in,
   input wire logic               rst_n_in,
   input wire logic               convert_start_n_in,
   input wire logic [DATA_W-1:0]  adc_result_in,
   input wire acr_pkg::acr_mode_s mode_in,
   input wire logic [1:0]         clock_divider_select_in,
   input wire logic               cs_n_in,
   input wire logic               rd_n_in,
   input wire logic               ext_sclk_in,
   input wire logic               serial_chain_in,
   input wire logic               busy_out,
   input wire logic [DATA_W-1:0]  data_out,
   input wire logic               data_oe_out,
   input wire logic               sync_out,
   input wire logic               sync_oe_out,
   input wire logic               sclk_out,
   input wire logic               sclk_oe_out,
   input wire logic               serial_result_out,
   input wire logic               serial_result_oe_out
);
   logic [19:0] busy_q;
   logic [19:0] low_q;
   wire logic [1:0]  sel = clock_divider_select_in;
   wire logic        par = !mode_in.serial;
   wire logic        mst = mode_in.serial && !mode_in.slave;
   wire logic        rac = mst && mode_in.read_after;
   wire logic        rdc = mst && !mode_in.read_after;
   wire logic [19:0] lim = sel[1] ? (sel[0] ? 20'h002CE : 20'h001B5) : (sel[0] ? 20'h00138 : 20'h000FA);
   wire logic [19:0] tail = sel[1] ? (sel[0] ? 20'h00025 : 20'h00011) : (sel[0] ? 20'h00007 : 20'h00001);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_q <= '0;
         low_q <= '0;
      end else begin
         busy_q <= busy_out ? busy_q + 20'h00001 : '0;
         low_q <= sclk_out ? '0 : low_q + 20'h00001;
      end
   end
   default clocking dc @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_busy_rise: assert property ($fell(convert_start_n_in) && !busy_out |-> ##[1:4] busy_out)
      else $error("busy late after start");
   a_busy_width: assert property (busy_out && !rac |-> busy_q < 20'h0009C)
      else $error("busy too long");
   a_rac_busy: assert property (busy_out && rac |-> busy_q < lim)
      else $error("busy too long in read-after");
   a_data_early: assert property ($fell(busy_out) && par |-> data_out == $past(data_out, 2))
      else $error("data late before busy fall");
   a_bus_drive: assert property (par && !cs_n_in && !rd_n_in |=> data_oe_out)
      else $error("bus not driven");
   a_bus_release: assert property (cs_n_in || rd_n_in |=> !data_oe_out)
      else $error("bus not released");
   a_master_on: assert property (mst && !cs_n_in |=> sync_oe_out && sclk_oe_out && serial_result_oe_out)
      else $error("serial outputs not driven");
   a_serial_off: assert property (cs_n_in |=> !sync_oe_out && !sclk_oe_out && !serial_result_oe_out)
      else $error("serial outputs not released");
   a_rdc_sync: assert property ($rose(sync_out) && rdc |-> busy_q inside {[20'h0003C:20'h00046]})
      else $error("frame marker misplaced");
   a_rac_sync: assert property ($rose(sync_out) && rac |-> busy_q inside {[20'h00096:20'h000AA]})
      else $error("frame marker misplaced");
   a_sync_tail: assert property ($fell(sync_out) && rac |-> low_q >= tail)
      else $error("frame marker dropped early");
   a_busy_drop: assert property ($fell(sync_out) && rac |-> ##[2:4] $fell(busy_out))
      else $error("busy not dropped after frame");
   c_par_done: cover property ($fell(busy_out) && par);
   c_rac_frame: cover property ($rose(sync_out) && rac);
   c_rdc_frame: cover property ($rose(sync_out) && rdc);
endmodule
bind acr_top acr_top_asserts #(.DATA_W(DATA_W)) acr_top_asserts_i (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .convert_start_n_in(convert_start_n_in),
   .adc_result_in(adc_result_in), .mode_in(mode_in), .clock_divider_select_in(clock_divider_select_in),
   .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .ext_sclk_in(ext_sclk_in), .serial_chain_in(serial_chain_in),
   .busy_out(busy_out), .data_out(data_out), .data_oe_out(data_oe_out), .sync_out(sync_out),
   .sync_oe_out(sync_oe_out), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out),
   .serial_result_out(serial_result_out), .serial_result_oe_out(serial_result_oe_out));
`default_nettype wire

/* File: test/acr_top_bench.sv */
// Self-checking bench of the conversion and readout block.
// Assumes the bound checker and the host model on the master serial port.
`timescale 1ns/1ps
`default_nettype none
module acr_top_bench;
   import acr_pkg::*;
   localparam logic [9:0] LIM [4] = '{10'h0FA, 10'h138, 10'h1B5, 10'h2CE};
   localparam logic [9:0] PMIN [4] = '{10'h019, 10'h032, 10'h064, 10'h0C8};
   localparam logic [9:0] PMAX [4] = '{10'h028, 10'h046, 10'h08C, 10'h118};
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        convert_start_n_in = 1'b1;
   logic [15:0] adc_result_in = 16'h0000;
   acr_mode_s   mode_in = '0;
   logic [1:0]  clock_divider_select_in = 2'h0;
   logic        cs_n_in = 1'b1;
   logic        rd_n_in = 1'b1;
   logic        ext_sclk_in = 1'b0;
   wire logic   serial_chain_in, busy_out, data_oe_out, sync_out, sync_oe_out, sclk_out, sclk_oe_out;
   wire logic   serial_result_out, serial_result_oe_out;
   wire logic [15:0] data_out, h_word;
   wire logic [5:0]  h_nbits;
   wire logic [9:0]  h_pmin, h_pmax;
   int          n_fail = 0;
   int          n_tests = 0;
   int          bw;
   always #4 clk_in = ~clk_in;
   acr_top acr_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .convert_start_n_in(convert_start_n_in),
      .adc_result_in(adc_result_in), .mode_in(mode_in), .clock_divider_select_in(clock_divider_select_in),
      .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .ext_sclk_in(ext_sclk_in), .serial_chain_in(serial_chain_in),
      .busy_out(busy_out), .data_out(data_out), .data_oe_out(data_oe_out), .sync_out(sync_out),
      .sync_oe_out(sync_oe_out), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out),
      .serial_result_out(serial_result_out), .serial_result_oe_out(serial_result_oe_out));
   acr_host_model acr_host_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_out),
      .sync_in(sync_out), .sd_in(serial_result_out), .word_out(h_word), .nbits_out(h_nbits),
      .per_min_out(h_pmin), .per_max_out(h_pmax), .chain_out(serial_chain_in));
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic results();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic do_reset(input acr_mode_s m, input logic [1:0] s, input logic c);
      @(negedge clk_in);
      rst_n_in = 1'b0;
      mode_in = m;
      clock_divider_select_in = s;
      cs_n_in = c;
      repeat (10) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (2) @(negedge clk_in);
   endtask
   task automatic convert(input logic [15:0] v);
      int t;
      t = 0;
      @(negedge clk_in);
      adc_result_in = v;
      convert_start_n_in = 1'b0;
      while (busy_out !== 1'b1 && t < 8) begin
         @(negedge clk_in);
         t++;
      end
      check("busy rise", 1, t <= 4);
      convert_start_n_in = 1'b1;
      bw = 0;
      while (busy_out === 1'b1 && bw < 1000) begin
         @(negedge clk_in);
         bw++;
      end
      check("busy fall", 1, bw < 1000);
      if (bw >= 1000) results();
      repeat (1250 - t - bw) @(negedge clk_in);
   endtask
   task automatic s_parallel();
      convert(16'hA5C3);
      check("busy width", 1, bw <= 156);
      check("parallel data", 16'hA5C3, data_out);
      cs_n_in = 1'b0;
      rd_n_in = 1'b0;
      @(negedge clk_in);
      check("bus drive", 1, data_oe_out);
      rd_n_in = 1'b1;
      @(negedge clk_in);
      check("bus release", 0, data_oe_out);
      cs_n_in = 1'b1;
      convert(16'h5A3C);
      check("next data", 16'h5A3C, data_out);
   endtask
   task automatic s_frame(input logic [15:0] v, input int s);
      check("frame word", v, h_word);
      check("frame bits", 16, h_nbits);
      check("clock period", 1, h_pmin * 8 >= PMIN[s] && h_pmax * 8 <= PMAX[s]);
   endtask
   task automatic s_slave(input logic [15:0] v);
      logic [15:0] w;
      convert(v);
      for (int i = 15; i >= 0; i--) begin
         w[i] = serial_result_out;
         ext_sclk_in = 1'b1;
         repeat (2) @(negedge clk_in);
         ext_sclk_in = 1'b0;
         repeat (2) @(negedge clk_in);
      end
      check("slave word", v, w);
   endtask
   initial begin
      do_reset('{1'b0, 1'b0, 1'b0}, 2'h0, 1'b1);
      check("reset busy", 0, busy_out);
      check("reset data", 0, {data_out, data_oe_out, sync_oe_out});
      s_parallel();
      for (int s = 0; s < 4; s++) begin
         do_reset('{1'b1, 1'b0, 1'b1}, 2'(s), 1'b0);
         convert({2'(s), 14'h15A3});
         check("read-after busy", 1, bw <= LIM[s]);
         s_frame({2'(s), 14'h15A3}, s);
      end
      do_reset('{1'b1, 1'b0, 1'b0}, 2'h3, 1'b0);
      convert(16'h3C96);
      convert(16'hE718);
      s_frame(16'h3C96, 0);
      check("serial drive", 3'h7, {sync_oe_out, sclk_oe_out, serial_result_oe_out});
      cs_n_in = 1'b1;
      @(negedge clk_in);
      check("serial release", 3'h0, {sync_oe_out, sclk_oe_out, serial_result_oe_out});
      do_reset('{1'b1, 1'b1, 1'b0}, 2'h0, 1'b0);
      s_slave(16'hB2D4);
      s_slave(16'h4B2D);
      results();
   end
endmodule
`default_nettype wire

/* File: verilog/acr_params.svh */
// Timing and sizing constants of the conversion and readout block.
// Assumes a single 125 MHz system clock; all counts derive from its period.
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// System clock period
`define ACR_CLK_NS            8

// Result word
`define ACR_DATA_W            16
`define ACR_BUF_DEPTH         2

// Host spacing of start pulses (host side, not enforced here)
`define ACR_T_START_SPACE_NS  10000

// Internal conversion time, kept inside the 1250 ns busy bound
`define ACR_T_CONV_NS         1120
`define ACR_CONV_CYC          (`ACR_T_CONV_NS / `ACR_CLK_NS)

// Busy limits for the non read-after modes
`define ACR_T_BUSY_RISE_NS    35
`define ACR_T_BUSY_MAX_NS     1250
`define ACR_T_EOC_BUSY_NS     10
`define ACR_T_DV_BUSY_NS      12
`define ACR_SETTLE_CYC        ((`ACR_T_DV_BUSY_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS + 3)

// Frame marker placement
`define ACR_T_SYNC_RDC_NS     525
`define ACR_SYNC_RDC_CYC      (`ACR_T_SYNC_RDC_NS / `ACR_CLK_NS)
`define ACR_T_SYNC_RAC_NS     1250
`define ACR_SYNC_RAC_CYC      (`ACR_T_SYNC_RAC_NS / `ACR_CLK_NS)
`define ACR_T_SYNC_BUSY_NS    25
`define ACR_SYNC_BUSY_CYC     (`ACR_T_SYNC_BUSY_NS / `ACR_CLK_NS)

// Serial clock: least period at select 00, doubled per select step
`define ACR_T_SCLK_MIN0_NS    25
`define ACR_SCLK_HALF_CYC     ((`ACR_T_SCLK_MIN0_NS + 2 * `ACR_CLK_NS - 1) / (2 * `ACR_CLK_NS))

// Last serial clock edge to frame marker removal, per select
`define ACR_T_TAIL0_NS        3
`define ACR_T_TAIL1_NS        55
`define ACR_T_TAIL2_NS        130
`define ACR_T_TAIL3_NS        290

`endif

/* File: verilog/acr_pkg.sv */
// Types shared by the conversion and readout block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package acr_pkg;

   typedef struct packed {
      logic serial;
      logic slave;
      logic read_after;
   } acr_mode_s;

   typedef enum logic [3:0] {
      CV_IDLE   = 4'h1,
      CV_RUN    = 4'h2,
      CV_SETTLE = 4'h4,
      CV_HOLD   = 4'h8
   } acr_conv_e;

   typedef enum logic [3:0] {
      SH_IDLE = 4'h1,
      SH_RUN  = 4'h2,
      SH_TAIL = 4'h4,
      SH_END  = 4'h8
   } acr_shift_e;

endpackage

`default_nettype wire

/* File: verilog/acr_top.sv */
// Conversion sequencer and result readout of a 16-bit sampling converter.
// Assumes synchronous pins, 125 MHz clock and a result from the analog core.
`timescale 1ns/1ps
`include "acr_params.svh"
`default_nettype none

module acr_top #(
   parameter int DATA_W    = `ACR_DATA_W,
   parameter int BUF_DEPTH = `ACR_BUF_DEPTH
) (
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   input  wire logic               convert_start_n_in,
   input  wire logic [DATA_W-1:0]  adc_result_in,
   input  wire acr_pkg::acr_mode_s mode_in,
   input  wire logic [1:0]         clock_divider_select_in,
   input  wire logic               cs_n_in,
   input  wire logic               rd_n_in,
   input  wire logic               ext_sclk_in,
   input  wire logic               serial_chain_in,
   output logic                    busy_out,
   output logic [DATA_W-1:0]       data_out,
   output logic                    data_oe_out,
   output logic                    sync_out,
   output logic                    sync_oe_out,
   output logic                    sclk_out,
   output logic                    sclk_oe_out,
   output logic                    serial_result_out,
   output logic                    serial_result_oe_out
);
   import acr_pkg::*;

   localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(BUF_DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] s, input logic b);
      shift_in = {s[DATA_W-2:0], b};
   endfunction

   function automatic logic [5:0] half_cyc(input logic [1:0] sel);
      half_cyc = 6'(`ACR_SCLK_HALF_CYC << sel);
   endfunction

   function automatic logic [5:0] tail_cyc(input logic [1:0] sel);
      logic [31:0] t;
      t = 0;
      if (sel == 2'h0) begin
         t = `ACR_T_TAIL0_NS;
      end else if (sel == 2'h1) begin
         t = `ACR_T_TAIL1_NS;
      end else if (sel == 2'h2) begin
         t = `ACR_T_TAIL2_NS;
      end else begin
         t = `ACR_T_TAIL3_NS;
      end
      tail_cyc = 6'((t + `ACR_CLK_NS - 1) / `ACR_CLK_NS);
   endfunction

   // State
   acr_conv_e               cv_st_q;
   acr_shift_e              sh_st_q;
   logic [7:0]              cv_cnt_q;
   logic [7:0]              start_cnt_q;
   logic                    start_prev_q;
   logic                    busy_q;
   logic [DATA_W-1:0]       buf_mem_q [BUF_DEPTH];
   logic [PW-1:0]           buf_wr_q;
   logic [PW-1:0]           buf_rd_q;
   logic [PW:0]             buf_cnt_q;
   logic [DATA_W-1:0]       par_q;
   logic                    data_oe_q;
   logic                    mst_oe_q;
   logic                    ser_oe_q;
   logic [DATA_W-1:0]       sh_q;
   logic [4:0]              sh_left_q;
   logic [5:0]              half_cnt_q;
   logic [5:0]              tail_cnt_q;
   logic                    sclk_q;
   logic                    sync_q;
   logic                    ext_prev_q;

   // Decode
   wire                     master      = mode_in.serial & ~mode_in.slave;
   wire                     slave       = mode_in.serial & mode_in.slave;
   wire                     rac_mode    = master & mode_in.read_after;
   wire [1:0]               eff_sel     = mode_in.read_after ? clock_divider_select_in : 2'h0;
   wire                     start_fall  = start_prev_q & ~convert_start_n_in;
   wire                     start_take  = start_fall & (cv_st_q == CV_IDLE);
   wire                     buf_in_rdy  = (buf_cnt_q != (PW+1)'(BUF_DEPTH));
   wire                     buf_out_vld = (buf_cnt_q != '0);
   wire                     conv_end    = (cv_st_q == CV_RUN) && (cv_cnt_q == 8'h00);
   wire                     push        = conv_end & buf_in_rdy;
   wire                     rdc_go      = master & ~mode_in.read_after & (sh_st_q == SH_IDLE) & buf_out_vld
                                          & (start_cnt_q == 8'(`ACR_SYNC_RDC_CYC));
   wire                     rac_go      = rac_mode & (sh_st_q == SH_IDLE) & (cv_st_q == CV_HOLD) & buf_out_vld
                                          & (start_cnt_q == 8'(`ACR_SYNC_RAC_CYC));
   wire                     frame_go    = rdc_go | rac_go;
   wire                     slave_pull  = slave & (sh_left_q == 5'h00) & buf_out_vld;
   wire                     pop         = buf_out_vld & (~mode_in.serial | frame_go | slave_pull);
   wire                     half_done   = (half_cnt_q == 6'h00);
   wire                     sclk_fall   = (sh_st_q == SH_RUN) & half_done & sclk_q;
   wire                     sclk_rise   = (sh_st_q == SH_RUN) & half_done & ~sclk_q;
   wire                     frame_done  = (sh_st_q == SH_END) & (tail_cnt_q == 6'h00);
   wire                     ext_active  = slave & ~cs_n_in & ext_prev_q & ~ext_sclk_in;
   wire                     settle_end  = (cv_st_q == CV_SETTLE) && (cv_cnt_q == 8'h00);

   // Input edge history
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         start_prev_q <= 1'b1;
         ext_prev_q   <= 1'b0;
      end else begin
         start_prev_q <= convert_start_n_in;
         ext_prev_q   <= ext_sclk_in;
      end
   end

   // Time since start, saturating at the read-after marker point
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         start_cnt_q <= 8'(`ACR_SYNC_RAC_CYC);
      end else if (start_take) begin
         start_cnt_q <= 8'h01;
      end else if (start_cnt_q != 8'(`ACR_SYNC_RAC_CYC)) begin
         start_cnt_q <= start_cnt_q + 8'h01;
      end
   end

   // Conversion sequencer; starts while busy are ignored
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cv_st_q  <= CV_IDLE;
         cv_cnt_q <= 8'h00;
      end else begin
         case (cv_st_q)
            CV_IDLE: begin
               if (start_take) begin
                  cv_st_q  <= CV_RUN;
                  cv_cnt_q <= 8'(`ACR_CONV_CYC - 1);
               end
            end
            CV_RUN: begin
               if (cv_cnt_q != 8'h00) begin
                  cv_cnt_q <= cv_cnt_q - 8'h01;
               end else if (buf_in_rdy) begin
                  cv_st_q  <= CV_SETTLE;
                  cv_cnt_q <= 8'(`ACR_SETTLE_CYC - 1);
               end
            end
            CV_SETTLE: begin
               if (cv_cnt_q != 8'h00) begin
                  cv_cnt_q <= cv_cnt_q - 8'h01;
               end else begin
                  cv_st_q <= rac_mode ? CV_HOLD : CV_IDLE;
               end
            end
            CV_HOLD: begin
               if (frame_done) begin
                  cv_st_q <= CV_IDLE;
               end
            end
            default: begin
               cv_st_q <= CV_IDLE;
            end
         endcase
      end
   end

   // Busy: one cycle after start, low after settle or after the read-after frame
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_q <= 1'b0;
      end else if (start_take) begin
         busy_q <= 1'b1;
      end else if ((settle_end & ~rac_mode) | ((cv_st_q == CV_HOLD) & frame_done)) begin
         busy_q <= 1'b0;
      end
   end

   // Two-entry result buffer; a full buffer stalls the sequencer
   always_ff @(posedge clk_in) begin
      if (push) begin
         buf_mem_q[buf_wr_q] <= adc_result_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         buf_wr_q  <= '0;
         buf_rd_q  <= '0;
         buf_cnt_q <= '0;
      end else begin
         if (push) begin
            buf_wr_q <= ptr_inc(buf_wr_q);
         end
         if (pop) begin
            buf_rd_q <= ptr_inc(buf_rd_q);
         end
         if (push & ~pop) begin
            buf_cnt_q <= buf_cnt_q + 1'b1;
         end else if (pop & ~push) begin
            buf_cnt_q <= buf_cnt_q - 1'b1;
         end
      end
   end

   // Parallel result register, loaded the cycle after the word lands
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         par_q <= '0;
      end else if (pop & ~mode_in.serial) begin
         par_q <= buf_mem_q[buf_rd_q];
      end
   end

   // Output enables follow chip select one cycle later; the bus enable also follows read request
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_oe_q <= 1'b0;
         mst_oe_q  <= 1'b0;
         ser_oe_q  <= 1'b0;
      end else begin
         data_oe_q <= ~mode_in.serial & ~cs_n_in & ~rd_n_in;
         mst_oe_q  <= master & ~cs_n_in;
         ser_oe_q  <= mode_in.serial & ~cs_n_in;
      end
   end

   // Serial frame sequencer for master modes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sh_st_q    <= SH_IDLE;
         half_cnt_q <= 6'h00;
         tail_cnt_q <= 6'h00;
         sclk_q     <= 1'b0;
         sync_q     <= 1'b0;
      end else begin
         case (sh_st_q)
            SH_IDLE: begin
               if (frame_go) begin
                  sh_st_q    <= SH_RUN;
                  sync_q     <= 1'b1;
                  sclk_q     <= 1'b0;
                  half_cnt_q <= half_cyc(eff_sel) - 6'h01;
               end
            end
            SH_RUN: begin
               if (!half_done) begin
                  half_cnt_q <= half_cnt_q - 6'h01;
               end else if (sclk_q && sh_left_q == 5'h00) begin
                  sh_st_q    <= SH_TAIL;
                  sclk_q     <= 1'b0;
                  tail_cnt_q <= tail_cyc(eff_sel) - 6'h01;
               end else begin
                  sclk_q     <= ~sclk_q;
                  half_cnt_q <= half_cyc(eff_sel) - 6'h01;
               end
            end
            SH_TAIL: begin
               if (tail_cnt_q != 6'h00) begin
                  tail_cnt_q <= tail_cnt_q - 6'h01;
               end else begin
                  sync_q     <= 1'b0;
                  sh_st_q    <= SH_END;
                  tail_cnt_q <= 6'(`ACR_SYNC_BUSY_CYC - 1);
               end
            end
            SH_END: begin
               if (tail_cnt_q != 6'h00) begin
                  tail_cnt_q <= tail_cnt_q - 6'h01;
               end else begin
                  sh_st_q <= SH_IDLE;
               end
            end
            default: begin
               sh_st_q <= SH_IDLE;
            end
         endcase
      end
   end

   // Shift register shared by master and slave readout
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sh_q      <= '0;
         sh_left_q <= 5'h00;
      end else if (pop & mode_in.serial) begin
         sh_q      <= buf_mem_q[buf_rd_q];
         sh_left_q <= 5'(DATA_W);
      end else if (sclk_rise) begin
         sh_left_q <= sh_left_q - 5'h01;
      end else if (sclk_fall && sh_left_q != 5'h00) begin
         sh_q <= shift_in(sh_q, serial_chain_in);
      end else if (ext_active && sh_left_q != 5'h00) begin
         sh_q      <= shift_in(sh_q, serial_chain_in);
         sh_left_q <= sh_left_q - 5'h01;
      end
   end

   assign busy_out             = busy_q;
   assign data_out             = par_q;
   assign data_oe_out          = data_oe_q;
   assign sync_out             = sync_q;
   assign sync_oe_out          = mst_oe_q;
   assign sclk_out             = sclk_q;
   assign sclk_oe_out          = mst_oe_q;
   assign serial_result_out    = sh_q[DATA_W-1];
   assign serial_result_oe_out = ser_oe_q;

endmodule

`default_nettype wire
